// ==== inc/fmv_cfg.svh ====
// Register map, field positions, command codes and limits of the margin, verify and program sequencer.
// Assumes a byte-addressed 32-bit Avalon-MM bus and a 16-bit word-wide data-flash port.
`ifndef FMV_CFG_SVH
`define FMV_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FMV_OFF_STAT 8'h00
`define FMV_OFF_IDX 8'h04
`define FMV_OFF_PARAM 8'h08
`define FMV_OFF_MARGIN 8'h0c
`define FMV_OFF_CFG 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FMV_ST_COMMAND_COMPLETE_FLAG 7
`define FMV_ST_ACCESS_ERROR_FLAG 5
`define FMV_ST_PROTECTION_VIOLATION_FLAG 4
`define FMV_ST_MG1 1
`define FMV_ST_MG0 0
`define FMV_CFG_SPECIAL 0
`define FMV_CFG_DFPROT 1
`define FMV_CMD_MSB 15
`define FMV_CMD_LSB 8
// ----------------------------------------
// Commands, slots and indices
// ----------------------------------------
`define FMV_CMD_USER 8'h0d
`define FMV_CMD_FIELD 8'h0e
`define FMV_CMD_EV 8'h10
`define FMV_CMD_PROG 8'h11
`define FMV_NSLOT 6
`define FMV_IDX_MARGIN 3'h1
`define FMV_IDX_EV 3'h2
`define FMV_IDX_PMIN 3'h2
`define FMV_IDX_PMAX 3'h5
`define FMV_IDX_ONE 3'h1
`define FMV_SLOT_ADDR 1
`define FMV_SLOT_DATA 2
`define FMV_SLOT_DATA3 3'h2
// ----------------------------------------
// Blocks, margins and array limits
// ----------------------------------------
`define FMV_BLK_PF 2'h0
`define FMV_BLK_DF 2'h1
`define FMV_MRG_NORMAL 3'h0
`define FMV_MRG_USER_MAX 16'h0002
`define FMV_MRG_FIELD_MAX 16'h0004
`define FMV_DF_GHI 2'h0
`define FMV_DF_LO 16'h0400
`define FMV_DF_HI 16'h13ff
`define FMV_DF_LIMIT 18'h01400
`define FMV_ERASED 16'hffff
`endif

// ==== inc/fmv_pkg.sv ====
// Types shared by the sequencer and its helpers.
// Assumes fmv_cfg.svh supplies all numeric constants.
package fmv_pkg;
  typedef logic [15:0] fmv_word_t;
  typedef logic [17:0] fmv_gaddr_t;
  typedef logic [2:0] fmv_margin_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CHECK = 2'b01, ST_ISSUE = 2'b11, ST_WAIT = 2'b10} fmv_state_t;
  typedef enum logic {PH_WR = 1'b0, PH_RD = 1'b1} fmv_phase_t;
endpackage

// ==== verilog/fmv_range_chk.sv ====
// Address check of a data-flash word section.
// Assumes word addresses in bytes, words two bytes apart.
`timescale 1ns/1ps
`include "fmv_cfg.svh"
module fmv_range_chk
(
  input wire logic [1:0] gaddr_hi,
  input wire fmv_pkg::fmv_word_t gaddr_lo,
  input wire fmv_pkg::fmv_word_t nwords,
  output logic addr_bad,
  output logic misaligned,
  output logic breach
);
  import fmv_pkg::*;
  logic [17:0] end_excl;
  // Section end, one past the last byte
  assign end_excl = {2'h0, gaddr_lo} + {1'b0, nwords, 1'b0};
  assign addr_bad = (gaddr_hi != `FMV_DF_GHI) || (gaddr_lo < `FMV_DF_LO) || (gaddr_lo > `FMV_DF_HI);
  assign misaligned = gaddr_lo[0];
  assign breach = end_excl > `FMV_DF_LIMIT;
endmodule

// ==== verilog/fmv_flash_port.sv ====
// Single-access handshake toward the data-flash array.
// Assumes the array answers each request with a one-cycle df_ack.
`timescale 1ns/1ps
`include "fmv_cfg.svh"
module fmv_flash_port
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic we,
  input wire fmv_pkg::fmv_gaddr_t addr,
  input wire fmv_pkg::fmv_word_t wdata,
  output logic done,
  output fmv_pkg::fmv_word_t rdata,
  output logic rd_err,
  output logic rd_uncorr,
  output logic df_req,
  output logic df_we,
  output fmv_pkg::fmv_gaddr_t df_addr,
  output fmv_pkg::fmv_word_t df_wdata,
  input wire logic df_ack,
  input wire fmv_pkg::fmv_word_t df_rdata,
  input wire logic df_err,
  input wire logic df_uncorr
);
  import fmv_pkg::*;
  logic ack_take;
  assign ack_take = df_req && df_ack;
  // Request stays up until the array acknowledges
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      df_req <= 1'b0;
      df_we <= 1'b0;
      df_addr <= '0;
      df_wdata <= '0;
    end
    else if (start)
    begin
      df_req <= 1'b1;
      df_we <= we;
      df_addr <= addr;
      df_wdata <= wdata;
    end
    else if (ack_take)
      df_req <= 1'b0;
  end
  // Answer captured with the acknowledge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done <= 1'b0;
      rdata <= '0;
      rd_err <= 1'b0;
      rd_uncorr <= 1'b0;
    end
    else
    begin
      done <= ack_take;
      if (ack_take)
      begin
        rdata <= df_rdata;
        rd_err <= df_err && !df_we;
        rd_uncorr <= df_uncorr && !df_we;
      end
    end
  end
endmodule

// ==== verilog/fmv_seq.sv ====
// Flash command sequencer: margin levels, data-flash erase-verify and program.
// Assumes an Avalon-MM master on the register side and one data-flash array port.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fmv_cfg.svh"
module fmv_seq
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output fmv_pkg::fmv_margin_t pf_read_margin,
  output fmv_pkg::fmv_margin_t df_read_margin,
  output logic df_req,
  output logic df_we,
  output fmv_pkg::fmv_gaddr_t df_addr,
  output fmv_pkg::fmv_word_t df_wdata,
  input wire logic df_ack,
  input wire fmv_pkg::fmv_word_t df_rdata,
  input wire logic df_err,
  input wire logic df_uncorr
);
  import fmv_pkg::*;
  fmv_state_t state, next_state;
  fmv_phase_t phase, next_phase;
  fmv_word_t slot [`FMV_NSLOT];
  fmv_word_t wptr, next_wptr, cnt, next_cnt;
  logic [2:0] idx;
  logic command_complete_flag, next_command_complete_flag, access_error_flag, next_access_error_flag, protection_violation_flag, next_protection_violation_flag;
  logic mg1, next_mg1, mg0, next_mg0;
  logic special, dfprot;
  fmv_margin_t next_pf, next_df;
  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic acc_req, wr_hit, sel_stat, sel_idx, sel_param, sel_margin, sel_cfg;
  logic launch, w1c_acc, w1c_fpv, slot_wr_ok;
  logic [31:0] rd_mux;
  // One wait cycle: request seen with waitrequest high, answered on the next edge
  assign acc_req = (avs_read || avs_write) && avs_waitrequest;
  assign wr_hit = avs_write && !avs_waitrequest;
  assign sel_stat = avs_address == `FMV_OFF_STAT;
  assign sel_idx = avs_address == `FMV_OFF_IDX;
  assign sel_param = avs_address == `FMV_OFF_PARAM;
  assign sel_margin = avs_address == `FMV_OFF_MARGIN;
  assign sel_cfg = avs_address == `FMV_OFF_CFG;
  assign launch = wr_hit && sel_stat && avs_byteenable[0] && avs_writedata[`FMV_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag;
  assign w1c_acc = wr_hit && sel_stat && avs_byteenable[0] && avs_writedata[`FMV_ST_ACCESS_ERROR_FLAG] && command_complete_flag;
  assign w1c_fpv = wr_hit && sel_stat && avs_byteenable[0] && avs_writedata[`FMV_ST_PROTECTION_VIOLATION_FLAG] && command_complete_flag;
  // Parameters are frozen while a command runs
  assign slot_wr_ok = wr_hit && sel_param && command_complete_flag && (idx < 3'(`FMV_NSLOT));
  // Read mux, unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_stat)
    begin
      rd_mux[`FMV_ST_COMMAND_COMPLETE_FLAG] = command_complete_flag;
      rd_mux[`FMV_ST_ACCESS_ERROR_FLAG] = access_error_flag;
      rd_mux[`FMV_ST_PROTECTION_VIOLATION_FLAG] = protection_violation_flag;
      rd_mux[`FMV_ST_MG1] = mg1;
      rd_mux[`FMV_ST_MG0] = mg0;
    end
    else if (sel_idx)
      rd_mux[2:0] = idx;
    else if (sel_param)
      rd_mux[15:0] = (idx < 3'(`FMV_NSLOT)) ? slot[idx] : 16'h0000;
    else if (sel_margin)
      rd_mux[10:0] = {df_read_margin, 5'h00, pf_read_margin};
    else if (sel_cfg)
      rd_mux[1:0] = {dfprot, special};
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= !acc_req;
      if (acc_req && avs_read)
        avs_readdata <= rd_mux;
    end
  end
  // Index, configuration and parameter slots
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idx <= 3'h0;
      special <= 1'b0;
      dfprot <= 1'b0;
      for (int i = 0; i < `FMV_NSLOT; i++)
        slot[i] <= 16'h0000;
    end
    else
    begin
      if (wr_hit && sel_idx && command_complete_flag && avs_byteenable[0])
        idx <= avs_writedata[2:0];
      if (wr_hit && sel_cfg && command_complete_flag && avs_byteenable[0])
      begin
        special <= avs_writedata[`FMV_CFG_SPECIAL];
        dfprot <= avs_writedata[`FMV_CFG_DFPROT];
      end
      if (slot_wr_ok && avs_byteenable[0])
        slot[idx][7:0] <= avs_writedata[7:0];
      if (slot_wr_ok && avs_byteenable[1])
        slot[idx][15:8] <= avs_writedata[15:8];
    end
  end
  // ----------------------------------------
  // Launch checks
  // ----------------------------------------
  logic [7:0] cmd;
  logic is_user, is_field, is_margin, is_ev, is_prog, known;
  logic blk_ok, set_ok, mode_ok, margin_err, ev_err, prog_err, idx_prog_ok;
  logic addr_bad, misal, breach, last, bad_word;
  fmv_word_t nwords, prog_words, expect_word;
  logic [2:0] data_slot;
  fmv_gaddr_t word_addr;
  assign cmd = slot[0][`FMV_CMD_MSB:`FMV_CMD_LSB];
  assign is_user = cmd == `FMV_CMD_USER;
  assign is_field = cmd == `FMV_CMD_FIELD;
  assign is_ev = cmd == `FMV_CMD_EV;
  assign is_prog = cmd == `FMV_CMD_PROG;
  assign is_margin = is_user || is_field;
  assign known = is_margin || is_ev || is_prog;
  assign blk_ok = (slot[0][1:0] == `FMV_BLK_PF) || (slot[0][1:0] == `FMV_BLK_DF);
  // Field settings extend the user range by two levels
  assign set_ok = is_field ? (slot[1] <= `FMV_MRG_FIELD_MAX) : (slot[1] <= `FMV_MRG_USER_MAX);
  assign mode_ok = !is_field || special;
  assign margin_err = (idx != `FMV_IDX_MARGIN) || !mode_ok || !blk_ok || !set_ok;
  // Count from the launch index, one word per slot beyond slot 1
  assign prog_words = {13'h0000, idx - `FMV_IDX_ONE};
  assign nwords = is_ev ? slot[`FMV_SLOT_DATA] : prog_words;
  assign idx_prog_ok = (idx >= `FMV_IDX_PMIN) && (idx <= `FMV_IDX_PMAX);
  assign ev_err = (idx != `FMV_IDX_EV) || addr_bad || misal || breach;
  assign prog_err = !idx_prog_ok || addr_bad || misal || breach;
  assign last = wptr == (cnt - 16'h0001);
  assign data_slot = wptr[2:0] + `FMV_SLOT_DATA3;
  assign word_addr = {slot[0][1:0], slot[`FMV_SLOT_ADDR]} + {1'b0, wptr, 1'b0};
  fmv_range_chk u_range
  (
    .gaddr_hi(slot[0][1:0]),
    .gaddr_lo(slot[`FMV_SLOT_ADDR]),
    .nwords(nwords),
    .addr_bad(addr_bad),
    .misaligned(misal),
    .breach(breach)
  );
  // ----------------------------------------
  // Array access
  // ----------------------------------------
  logic port_done, rd_err, rd_uncorr;
  fmv_word_t rdata;
  fmv_flash_port u_port
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(state == ST_ISSUE),
    .we(phase == PH_WR),
    .addr(word_addr),
    .wdata(slot[data_slot]),
    .done(port_done),
    .rdata(rdata),
    .rd_err(rd_err),
    .rd_uncorr(rd_uncorr),
    .df_req(df_req),
    .df_we(df_we),
    .df_addr(df_addr),
    .df_wdata(df_wdata),
    .df_ack(df_ack),
    .df_rdata(df_rdata),
    .df_err(df_err),
    .df_uncorr(df_uncorr)
  );
  // Erase-verify expects blank words, program verify expects the written value
  assign expect_word = is_ev ? `FMV_ERASED : slot[data_slot];
  assign bad_word = rdata != expect_word;
  // ----------------------------------------
  // Command state machine
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_wptr = wptr;
    next_cnt = cnt;
    next_command_complete_flag = command_complete_flag;
    next_access_error_flag = access_error_flag && !w1c_acc;
    next_protection_violation_flag = protection_violation_flag && !w1c_fpv;
    next_mg1 = mg1;
    next_mg0 = mg0;
    next_pf = pf_read_margin;
    next_df = df_read_margin;
    case (state)
      ST_IDLE:
        if (launch)
        begin
          next_state = ST_CHECK;
          next_command_complete_flag = 1'b0;
          next_access_error_flag = 1'b0;
          next_protection_violation_flag = 1'b0;
          next_mg1 = 1'b0;
          next_mg0 = 1'b0;
        end
      ST_CHECK:
      begin
        next_state = ST_IDLE;
        next_command_complete_flag = 1'b1;
        if (!known || (is_margin && margin_err) || (is_ev && ev_err) || (is_prog && prog_err))
          next_access_error_flag = 1'b1;
        else if (is_margin)
        begin
          // Program-flash level reaches both arrays, data-flash level only its own
          next_df = slot[1][2:0];
          if (slot[0][1:0] == `FMV_BLK_PF)
            next_pf = slot[1][2:0];
        end
        else if (is_prog && dfprot)
          next_protection_violation_flag = 1'b1;
        else if (nwords != 16'h0000)
        begin
          next_state = ST_ISSUE;
          next_command_complete_flag = 1'b0;
          next_cnt = nwords;
          next_wptr = 16'h0000;
          next_phase = is_ev ? PH_RD : PH_WR;
        end
      end
      ST_ISSUE:
        next_state = ST_WAIT;
      ST_WAIT:
        if (port_done)
        begin
          next_state = ST_ISSUE;
          next_wptr = wptr + 16'h0001;
          if (phase == PH_WR)
          begin
            // After the last write the same words are read back
            if (last)
            begin
              next_phase = PH_RD;
              next_wptr = 16'h0000;
            end
          end
          else
          begin
            next_mg1 = mg1 || rd_err || bad_word;
            next_mg0 = mg0 || rd_uncorr || (is_ev && bad_word);
            if (last)
            begin
              next_state = ST_IDLE;
              next_command_complete_flag = 1'b1;
            end
          end
        end
      default:
        next_state = ST_IDLE;
    endcase
  end
  // Margin levels survive until the next margin command or reset
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      phase <= PH_WR;
      wptr <= 16'h0000;
      cnt <= 16'h0000;
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      mg1 <= 1'b0;
      mg0 <= 1'b0;
      pf_read_margin <= `FMV_MRG_NORMAL;
      df_read_margin <= `FMV_MRG_NORMAL;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      wptr <= next_wptr;
      cnt <= next_cnt;
      command_complete_flag <= next_command_complete_flag;
      access_error_flag <= next_access_error_flag;
      protection_violation_flag <= next_protection_violation_flag;
      mg1 <= next_mg1;
      mg0 <= next_mg0;
      pf_read_margin <= next_pf;
      df_read_margin <= next_df;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  busy_flag_low_a: assert property (@(posedge mclk) disable iff (sys_rst) (state != ST_IDLE) |-> !command_complete_flag)
    else $error("complete flag high while busy");
  launch_clears_a: assert property (@(posedge mclk) disable iff (sys_rst)
    launch |=> !command_complete_flag && !access_error_flag && !protection_violation_flag && !mg1 && !mg0 ##1 (state != ST_CHECK))
    else $error("launch did not clear flags");
  margin_apply_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_margin && !margin_err) |=> command_complete_flag && df_read_margin == $past(slot[1][2:0]))
    else $error("margin level not applied");
  pf_both_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_margin && !margin_err && slot[0][1:0] == `FMV_BLK_PF)
    |=> pf_read_margin == df_read_margin)
    else $error("program-flash level missed data-flash");
  df_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && slot[0][1:0] == `FMV_BLK_DF) |=> $stable(pf_read_margin))
    else $error("data-flash level changed program-flash");
  user_idx_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_user && idx != `FMV_IDX_MARGIN) |=> access_error_flag && command_complete_flag && !mg1 && !mg0)
    else $error("user margin index error missed");
  field_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_field && !special) |=> access_error_flag && !protection_violation_flag && $stable(df_read_margin))
    else $error("field margin outside special mode");
  ev_idx_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_ev && idx != `FMV_IDX_EV) |=> access_error_flag && state == ST_IDLE)
    else $error("erase-verify index error missed");
  blank_fail_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_WAIT && port_done && is_ev && bad_word) |=> mg1 && mg0)
    else $error("blank check failure not flagged");
  ev_no_prot_a: assert property (@(posedge mclk) disable iff (sys_rst) (is_ev && state != ST_IDLE) |-> !protection_violation_flag)
    else $error("protection flag on erase-verify");
  prog_idx_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == ST_CHECK && is_prog && (idx < `FMV_IDX_PMIN || idx > `FMV_IDX_PMAX)) |=> access_error_flag)
    else $error("program index error missed");
  margin_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state != ST_CHECK) |=> $stable(pf_read_margin) && $stable(df_read_margin))
    else $error("margin changed without command");
  wait_one_a: assert property (@(posedge mclk) disable iff (sys_rst) !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
endmodule

// ==== tb/fmv_seq_tb.sv ====
// Bench for fmv_seq: margin, erase-verify and program commands.
// Assumes fmv_cfg.svh and fmv_pkg; the bench plays the data-flash array.
`timescale 1ns/1ps
`include "fmv_cfg.svh"
module fmv_seq_tb;
  import fmv_pkg::*;
  // ----------------------------------------
  // Signals and array stand-in
  // ----------------------------------------
  localparam logic [7:0] ST = `FMV_OFF_STAT;
  localparam logic [7:0] IX = `FMV_OFF_IDX;
  localparam logic [7:0] PM = `FMV_OFF_PARAM;
  localparam logic [7:0] CF = `FMV_OFF_CFG;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fmv_margin_t pf_read_margin;
  fmv_margin_t df_read_margin;
  logic df_req;
  logic df_we;
  fmv_gaddr_t df_addr;
  fmv_word_t df_wdata;
  logic df_ack = 1'b0;
  fmv_word_t df_rdata = 16'h0;
  logic df_err = 1'b0;
  logic df_uncorr = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int wt = 0;
  int rd_n = 0;
  fmv_word_t mem [0:4095];
  fmv_gaddr_t bad_a = 18'h3ffff;
  fmv_word_t flip = 16'h0000;
  logic bad_u = 1'b0;
  fmv_gaddr_t wa_q[$];
  fmv_word_t wd_q[$];
  logic [31:0] s;

  fmv_seq dut_u
  (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pf_read_margin(pf_read_margin), .df_read_margin(df_read_margin), .df_req(df_req),
    .df_we(df_we), .df_addr(df_addr), .df_wdata(df_wdata), .df_ack(df_ack),
    .df_rdata(df_rdata), .df_err(df_err), .df_uncorr(df_uncorr)
  );

  always #10 mclk = ~mclk;

  // Array acks two cycles into a request; read data toggles off the ack so stale values never match
  always @(posedge mclk)
  begin
    df_ack <= 1'b0;
    df_err <= 1'b0;
    df_uncorr <= 1'b0;
    df_rdata <= ~df_rdata;
    if (df_req === 1'b1 && df_ack === 1'b0)
      wt++;
    if (wt == 2)
    begin
      wt = 0;
      df_ack <= 1'b1;
      if (df_we)
      begin
        mem[df_addr[12:1]] = df_wdata;
        wa_q.push_back(df_addr);
        wd_q.push_back(df_wdata);
      end
      else
      begin
        rd_n++;
        df_rdata <= mem[df_addr[12:1]] ^ flip;
        df_err <= (df_addr == bad_a);
        df_uncorr <= (df_addr == bad_a) && bad_u;
      end
    end
  end

  // ----------------------------------------
  // Tasks and scenarios
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One access; held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    q = avs_readdata;
    if (n == 20)
      chk("waitrequest", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Load n slots, leave index at ix, launch, poll for completion, judge status
  task automatic go(input logic [15:0] p [6], input int n, input logic [2:0] ix, input logic [7:0] e);
    int k;
    k = 0;
    for (int i = 0; i < n; i++)
    begin
      wr(IX, 32'(i));
      wr(PM, {16'h0, p[i]});
    end
    wr(IX, {29'h0, ix});
    wr(ST, 32'h80);
    s = 32'h0;
    while (s[7] !== 1'b1 && k < 200)
    begin
      bus(1'b0, ST, 32'h0, s);
      k++;
    end
    chk("status", {24'h0, e}, s);
  endtask

  task automatic mrg(input logic [7:0] c, input logic [1:0] b, input logic [15:0] l, input logic [2:0] ix,
                     input logic [7:0] e, input logic [2:0] ep, input logic [2:0] ed);
    go('{{c, 6'h0, b}, l, 16'h0, 16'h0, 16'h0, 16'h0}, 2, ix, e);
    chk("margins", {26'h0, ep, ed}, {26'h0, pf_read_margin, df_read_margin});
  endtask

  task automatic t_user;
    bus(1'b0, 8'h40, 32'h0, s);
    chk("unmapped", 32'h0, s);
    chk("margins", 32'h0, {26'h0, pf_read_margin, df_read_margin});
    for (int l = 0; l < 3; l++)
      mrg(`FMV_CMD_USER, `FMV_BLK_PF, 16'(l), 3'h1, 8'h80, 3'(l), 3'(l));
    mrg(`FMV_CMD_USER, `FMV_BLK_DF, 16'h1, 3'h1, 8'h80, 3'h2, 3'h1);
    bus(1'b0, `FMV_OFF_MARGIN, 32'h0, s);
    chk("margin reg", 32'h102, s);
    bus(1'b0, PM, 32'h0, s);
    chk("param", 32'h1, s);
    bus(1'b0, IX, 32'h0, s);
    chk("index", 32'h1, s);
    mrg(`FMV_CMD_USER, `FMV_BLK_DF, 16'h3, 3'h1, 8'ha0, 3'h2, 3'h1);
    mrg(`FMV_CMD_USER, 2'h2, 16'h1, 3'h1, 8'ha0, 3'h2, 3'h1);
    mrg(8'h20, `FMV_BLK_PF, 16'h0, 3'h1, 8'ha0, 3'h2, 3'h1);
    mrg(`FMV_CMD_USER, `FMV_BLK_PF, 16'h0, 3'h0, 8'ha0, 3'h2, 3'h1);
    wr(ST, 32'h20);
    bus(1'b0, ST, 32'h0, s);
    chk("cleared", 32'h80, s);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("margins", 32'h0, {26'h0, pf_read_margin, df_read_margin});
  endtask

  task automatic t_field;
    mrg(`FMV_CMD_FIELD, `FMV_BLK_DF, 16'h3, 3'h1, 8'ha0, 3'h0, 3'h0);
    wr(CF, 32'h1);
    bus(1'b0, CF, 32'h0, s);
    chk("config", 32'h1, s);
    for (int l = 0; l < 5; l++)
      mrg(`FMV_CMD_FIELD, `FMV_BLK_DF, 16'(l), 3'h1, 8'h80, 3'h0, 3'(l));
    mrg(`FMV_CMD_FIELD, `FMV_BLK_PF, 16'h4, 3'h1, 8'h80, 3'h4, 3'h4);
    mrg(`FMV_CMD_FIELD, `FMV_BLK_PF, 16'h5, 3'h1, 8'ha0, 3'h4, 3'h4);
    mrg(`FMV_CMD_FIELD, `FMV_BLK_PF, 16'h3, 3'h2, 8'ha0, 3'h4, 3'h4);
    wr(CF, 32'h0);
  endtask

  task automatic t_ev;
    logic [15:0] p [6];
    p = '{16'h1000, 16'h0400, 16'h4, 16'h0, 16'h0, 16'h0};
    rd_n = 0;
    go(p, 3, 3'h2, 8'h80);
    chk("reads", 32'h4, rd_n);
    p[2] = 16'h0;
    rd_n = 0;
    go(p, 3, 3'h2, 8'h80);
    chk("reads", 32'h0, rd_n);
    p[2] = 16'h4;
    mem[12'h203] = 16'h1234;
    go(p, 3, 3'h2, 8'h83);
    mem[12'h203] = 16'hffff;
    bad_a = 18'h00402;
    go(p, 3, 3'h2, 8'h82);
    bad_u = 1'b1;
    go(p, 3, 3'h2, 8'h83);
    bad_a = 18'h3ffff;
    go(p, 3, 3'h1, 8'ha0);
    p[1] = 16'h0401;
    go(p, 3, 3'h2, 8'ha0);
    p[1] = 16'h13fe;
    go(p, 3, 3'h2, 8'ha0);
  endtask

  task automatic t_prog;
    logic [15:0] p [6];
    p = '{16'h1100, 16'h0408, 16'ha001, 16'hb002, 16'hc003, 16'hd004};
    rd_n = 0;
    go(p, 6, 3'h5, 8'h80);
    chk("writes", 32'h4, wa_q.size());
    chk("reads", 32'h4, rd_n);
    for (int i = 0; i < 4; i++)
    begin
      chk("wr addr", 32'h408 + 32'(2 * i), {14'h0, wa_q[i]});
      chk("wr data", {16'h0, p[i + 2]}, {16'h0, wd_q[i]});
    end
    wa_q.delete();
    p[1] = 16'h0410;
    go(p, 6, 3'h2, 8'h80);
    chk("writes", 32'h1, wa_q.size());
    p[1] = 16'h0420;
    go(p, 6, 3'h1, 8'ha0);
    go(p, 6, 3'h6, 8'ha0);
    p[1] = 16'h0421;
    go(p, 6, 3'h2, 8'ha0);
    p[1] = 16'h13fe;
    go(p, 6, 3'h3, 8'ha0);
    // Read-back corrupted by one bit: program verify must flag the upper bit only
    flip = 16'h0001;
    p[1] = 16'h0430;
    go(p, 6, 3'h2, 8'h82);
    flip = 16'h0000;
    wr(CF, 32'h2);
    p[1] = 16'h0420;
    go(p, 6, 3'h2, 8'h90);
  endtask

  // Main sequence and watchdog share the one closing task
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 16'hffff;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_user();
    t_field();
    t_ev();
    t_prog();
    test_done();
  end

  initial
  begin
    #1000000;
    fail_count++;
    test_done();
  end
endmodule
